/* dab_defines.svh */
// Constants for the dual-address bus cycle sequencer.
`ifndef DAB_DEFINES_SVH
`define DAB_DEFINES_SVH
`define DAB_AD_W          16
`define DAB_ADDR_W        24
`define DAB_FC_W          3
`define DAB_BEC_W         3
`define DAB_SYNC_RST      21'h1FFFFF
`define DAB_STRAP_WAIT    2'h2
`define DAB_BEC_NORMAL    3'h7
`define DAB_BEC_HALT      3'h5
`define DAB_BEC_BERR      3'h4
`define DAB_BEC_RETRY     3'h3
`define DAB_BEC_RELRETRY  3'h2
`define DAB_BEC_RESET     3'h0
`endif

/* dab_pkg.sv */
// Types shared by the dual-address bus cycle sequencer.
package dab_pkg;
   typedef enum logic [2:0] {
      TC_NORMAL, TC_BERR, TC_RETRY, TC_RELRETRY, TC_HALT, TC_RESET
   } dab_term_t;

   typedef enum logic [3:0] {
      ST_IDLE, ST_S0, ST_S1, ST_S2, ST_S3, ST_S4, ST_S5, ST_S6, ST_S7,
      ST_S8, ST_S9, ST_E1, ST_E2, ST_W1
   } dab_state_t;

   typedef struct packed {
      logic        write;
      logic        to_dev;
      logic        last;
      logic        byte_op;
      logic        dev8;
      logic        dev_odd;
      logic [15:0] wdata;
   } dab_req_t;

   typedef struct packed {
      logic [2:0]  mem_fc;
      logic [23:0] mem_addr;
      logic [2:0]  dev_fc;
      logic [23:0] dev_addr;
   } dab_chan_t;

   typedef struct packed {
      logic [2:0]  fc;
      logic        fc_oe;
      logic [6:0]  addr_lo;
      logic [15:0] ad;
      logic        ad_oe;
      logic        uas_n;
      logic        as_n;
      logic        rw;
      logic        upper_strobe_or_addr_zero;
      logic        lower_strobe_or_single_strobe_n;
      logic        ctl_oe;
      logic        data_buffer_enable_n;
      logic        data_direction;
      logic        ack_n;
      logic        last_n;
      logic        dtc_n;
   } dab_pins_t;
endpackage : dab_pkg

/* dab_sync.sv */
// Two-stage synchroniser for a bundle of asynchronous inputs.
`timescale 1ns/1ps
module dab_sync #(
   parameter int          W       = 21,
   parameter logic [20:0] RST_VAL = 21'h1FFFFF
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] dout
);
   logic [W-1:0] meta_q;

   // The first stage is read only by the second.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= RST_VAL[W-1:0];
         dout   <= RST_VAL[W-1:0];
      end else begin
         meta_q <= din;
         dout   <= meta_q;
      end
   end
endmodule : dab_sync

/* dab_term_decode.sv */
// Decoder from the bus exception code to a termination class.
`timescale 1ns/1ps
`include "dab_defines.svh"
module dab_term_decode #(
   parameter logic [2:0] C_NORMAL   = `DAB_BEC_NORMAL,
   parameter logic [2:0] C_HALT     = `DAB_BEC_HALT,
   parameter logic [2:0] C_BERR     = `DAB_BEC_BERR,
   parameter logic [2:0] C_RETRY    = `DAB_BEC_RETRY,
   parameter logic [2:0] C_RELRETRY = `DAB_BEC_RELRETRY,
   parameter logic [2:0] C_RESET    = `DAB_BEC_RESET
) (
   input  wire logic [2:0]       code,
   output dab_pkg::dab_term_t    cls
);
   // Unlisted codes are taken as normal, so they never end a cycle.
   always_comb begin
      if (code == C_RESET)            cls = dab_pkg::TC_RESET;
      else if (code == C_BERR)        cls = dab_pkg::TC_BERR;
      else if (code == C_RETRY)       cls = dab_pkg::TC_RETRY;
      else if (code == C_RELRETRY)    cls = dab_pkg::TC_RELRETRY;
      else if (code == C_HALT)        cls = dab_pkg::TC_HALT;
      else                            cls = dab_pkg::TC_NORMAL;
   end
endmodule : dab_term_decode

/* dab_cycle.sv */
// Dual-address DMA bus cycle sequencer: read cycles S0 to S7, write cycles S0 to S9.
// What this block does
// - S0 drives function code and address from channel registers, latch strobe, R/W high.
// - On an 8-bit bus the upper strobe pin carries address bit zero from S0.
// - Read S2: drop latch strobe, raise address and data strobes, direction low.
// - Read to peripheral: acknowledge from S2, last-transfer flag on final device transfer.
// - Read S3: float address/data pins, enable buffers, sample termination inputs.
// - Read: acknowledge goes to S4; error codes add two waits; else wait.
// - Read data latched end of S5; unused byte lane ignored on 16-bit bus byte reads.
// - Transfer-complete in read S6 or write S8 only after normal termination.
// - Read S7 negates address strobe, data strobes and buffer enable.
// - After read S7: direction negated, address lines advance or float.
// - Next cycle starts right after normal termination; not required after exceptions.
// - Cycle end negates peripheral acknowledge, transfer-complete and last-transfer flag.
// - Write S0 drives data direction high, outward from the device.
// - Write S2: drop latch strobe, raise address strobe, drive R/W low.
// - Write S3: pins carry holding data, buffer enable asserted.
// - Write to peripheral: acknowledge and last flag from S3; sampling begins.
// - Write: early acknowledge skips S6,S7; early error adds one wait before S6.
// - Write S5: data strobes on; acknowledge to S6, errors two waits, else wait.
// - Write S9 negates address strobe and data strobes.
// - After write S9: buffer enable off, direction and R/W high.
// - 16-bit device on 8-bit bus: even address, word access, one strobe.
// - 8-bit peripheral on 16-bit bus uses the strobe of its byte half on byte operations.
// - Upper-byte steering pin at reset release selects 16-bit (high) or 8-bit bus.
`timescale 1ns/1ps
`include "dab_defines.svh"
module dab_cycle (
   input  wire logic               clk,
   input  wire logic               rst_n,
   // Request side from the channel logic.
   input  wire logic               req_valid,
   output logic                    req_ready,
   input  wire dab_pkg::dab_req_t  req,
   input  wire dab_pkg::dab_chan_t chan,
   output logic                    done,
   output dab_pkg::dab_term_t      done_status,
   output logic [15:0]             hold_data,
   output logic                    bus16,
   output logic                    bus_ready,
   // Bus pins.
   output dab_pkg::dab_pins_t      pins,
   input  wire logic [15:0]        ad_in,
   input  wire logic               transfer_acknowledge_n,
   input  wire logic [2:0]         bus_exception_code,
   input  wire logic               upper_byte_steer
);
   dab_pkg::dab_state_t state_q, state_d;
   dab_pkg::dab_req_t   cyc_q, cyc_d;
   dab_pkg::dab_term_t  term_q, term_d, cls, stat_q, stat_d;
   dab_pkg::dab_pins_t  pins_d;
   logic        skip_q, skip_d, early_q, early_d, done_q, done_d;
   logic [15:0] hold_q, hold_d;
   logic [1:0]  strap_cnt_q, strap_cnt_d;
   logic        bus16_q, bus16_d, strap_q, strap_d;
   logic [20:0] sync_out;
   logic [15:0] ad_s;
   logic        transfer_acknowledge_s, steer_s, is_err, is_end, accept, upper_lane;
   logic [2:0]  bec_s;

   // All asynchronous bus inputs pass two flip-flops before use.
   dab_sync #(.W(21), .RST_VAL(`DAB_SYNC_RST)) u_sync (
      .clk  (clk),
      .rst_n(rst_n),
      .din  ({upper_byte_steer, transfer_acknowledge_n, bus_exception_code, ad_in}),
      .dout (sync_out)
   );
   assign steer_s = sync_out[20];
   assign transfer_acknowledge_s = ~sync_out[19];
   assign bec_s   = sync_out[18:16];
   assign ad_s    = sync_out[15:0];

   dab_term_decode u_dec (
      .code(bec_s),
      .cls (cls)
   );

   assign is_err = (cls == dab_pkg::TC_BERR) || (cls == dab_pkg::TC_RETRY)
                || (cls == dab_pkg::TC_RELRETRY);
   assign is_end = (state_q == dab_pkg::ST_S7 && !cyc_q.write)
                || (state_q == dab_pkg::ST_S9 && cyc_q.write);
   // A new cycle follows at once only after a normal end.
   assign req_ready = strap_q && ((state_q == dab_pkg::ST_IDLE)
                   || (is_end && term_q == dab_pkg::TC_NORMAL));
   assign accept    = req_valid && req_ready;

   // Bus width is taken from the steering pin once the synchroniser has flushed.
   always_comb begin
      strap_cnt_d = strap_cnt_q;
      strap_d     = strap_q;
      bus16_d     = bus16_q;
      if (!strap_q) begin
         if (strap_cnt_q == `DAB_STRAP_WAIT) begin
            strap_d = 1'b1;
            bus16_d = steer_s;
         end else begin
            strap_cnt_d = strap_cnt_q + 2'h1;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         strap_cnt_q <= 2'h0;
         strap_q     <= 1'b0;
         bus16_q     <= 1'b0;
      end else begin
         strap_cnt_q <= strap_cnt_d;
         strap_q     <= strap_d;
         bus16_q     <= bus16_d;
      end
   end

   assign bus16     = bus16_q;
   assign bus_ready = strap_q;

   // Byte lane of the current cycle; an 8-bit device uses its own half.
   always_comb begin
      if (cyc_q.to_dev && cyc_q.dev8) upper_lane = ~cyc_q.dev_odd;
      else if (cyc_q.to_dev)          upper_lane = ~chan.dev_addr[0];
      else                            upper_lane = ~chan.mem_addr[0];
   end

   // Cycle sequencer: next state, termination class and holding register.
   always_comb begin
      state_d = state_q;
      cyc_d   = cyc_q;
      term_d  = term_q;
      skip_d  = skip_q;
      early_d = early_q;
      hold_d  = hold_q;
      done_d  = 1'b0;
      stat_d  = stat_q;
      unique case (state_q)
         dab_pkg::ST_IDLE: ;
         dab_pkg::ST_S0: state_d = dab_pkg::ST_S1;
         dab_pkg::ST_S1: state_d = dab_pkg::ST_S2;
         dab_pkg::ST_S2: state_d = dab_pkg::ST_S3;
         dab_pkg::ST_S3: begin
            if (cyc_q.write) begin
               state_d = dab_pkg::ST_S4;
               skip_d  = transfer_acknowledge_s;
               early_d = !transfer_acknowledge_s && is_err;
               if (!transfer_acknowledge_s && is_err) term_d = cls;
            end else if (transfer_acknowledge_s) begin
               state_d = dab_pkg::ST_S4;
               term_d  = dab_pkg::TC_NORMAL;
            end else if (is_err) begin
               state_d = dab_pkg::ST_E1;
               term_d  = cls;
            end
         end
         dab_pkg::ST_S4: state_d = dab_pkg::ST_S5;
         dab_pkg::ST_S5: begin
            if (!cyc_q.write) begin
               state_d = dab_pkg::ST_S6;
               if (term_q == dab_pkg::TC_NORMAL) begin
                  // Only the addressed byte lane is taken on byte reads of the 16-bit bus.
                  if (!cyc_q.byte_op || !bus16_q) hold_d = ad_s;
                  else if (upper_lane) hold_d[15:8] = ad_s[15:8];
                  else hold_d[7:0] = ad_s[7:0];
               end
            end else if (skip_q) begin
               state_d = dab_pkg::ST_S8;
               term_d  = dab_pkg::TC_NORMAL;
            end else if (early_q) begin
               state_d = dab_pkg::ST_W1;
            end else if (transfer_acknowledge_s) begin
               state_d = dab_pkg::ST_S6;
               term_d  = dab_pkg::TC_NORMAL;
            end else if (is_err) begin
               state_d = dab_pkg::ST_E1;
               term_d  = cls;
            end
         end
         dab_pkg::ST_W1: state_d = dab_pkg::ST_S6;
         dab_pkg::ST_E1: state_d = dab_pkg::ST_E2;
         dab_pkg::ST_E2: state_d = cyc_q.write ? dab_pkg::ST_S6 : dab_pkg::ST_S4;
         dab_pkg::ST_S6: state_d = dab_pkg::ST_S7;
         dab_pkg::ST_S7: state_d = cyc_q.write ? dab_pkg::ST_S8 : dab_pkg::ST_IDLE;
         dab_pkg::ST_S8: state_d = dab_pkg::ST_S9;
         dab_pkg::ST_S9: state_d = dab_pkg::ST_IDLE;
      endcase
      if (is_end) begin
         done_d = 1'b1;
         stat_d = term_q;
      end
      // A reset code aborts any cycle at once.
      if (state_q != dab_pkg::ST_IDLE && cls == dab_pkg::TC_RESET) begin
         state_d = dab_pkg::ST_IDLE;
         done_d  = 1'b1;
         stat_d  = dab_pkg::TC_RESET;
      end else if (accept) begin
         state_d = dab_pkg::ST_S0;
         cyc_d   = req;
         term_d  = dab_pkg::TC_NORMAL;
         skip_d  = 1'b0;
         early_d = 1'b0;
         if (req.write) hold_d = req.wdata;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= dab_pkg::ST_IDLE;
         cyc_q   <= '0;
         term_q  <= dab_pkg::TC_NORMAL;
         skip_q  <= 1'b0;
         early_q <= 1'b0;
         hold_q  <= 16'h0000;
         done_q  <= 1'b0;
         stat_q  <= dab_pkg::TC_NORMAL;
      end else begin
         state_q <= state_d;
         cyc_q   <= cyc_d;
         term_q  <= term_d;
         skip_q  <= skip_d;
         early_q <= early_d;
         hold_q  <= hold_d;
         done_q  <= done_d;
         stat_q  <= stat_d;
      end
   end

   assign done        = done_q;
   assign done_status = stat_q;
   assign hold_data   = hold_q;

   // Pin levels for the coming state, registered so the pins never glitch.
   always_comb begin
      logic        rd, wr, act, strobe_on, dev, upper, norm;
      logic [2:0]  fc;
      logic [23:0] addr;
      rd   = !cyc_d.write;
      wr   = cyc_d.write;
      act  = state_d != dab_pkg::ST_IDLE;
      dev  = cyc_d.to_dev;
      norm = term_d == dab_pkg::TC_NORMAL;
      fc   = dev ? chan.dev_fc : chan.mem_fc;
      addr = dev ? chan.dev_addr : chan.mem_addr;
      if (dev && cyc_d.dev8) upper = ~cyc_d.dev_odd;
      else                   upper = ~addr[0];
      strobe_on = 1'b0;
      pins_d = '0;
      pins_d.uas_n    = 1'b1;
      pins_d.as_n     = 1'b1;
      pins_d.rw       = 1'b1;
      pins_d.lower_strobe_or_single_strobe_n = 1'b1;
      pins_d.data_buffer_enable_n   = 1'b1;
      pins_d.data_direction     = 1'b1;
      pins_d.ack_n    = 1'b1;
      pins_d.last_n   = 1'b1;
      pins_d.dtc_n    = 1'b1;
      // Address lines float between cycles and advance when one follows.
      pins_d.fc_oe   = act;
      pins_d.ctl_oe  = act;
      pins_d.fc      = fc;
      pins_d.addr_lo = addr[7:1];
      pins_d.ad      = addr[23:8];
      pins_d.upper_strobe_or_addr_zero  = (dev && !cyc_d.dev8) ? 1'b0 : addr[0];
      unique case (state_d)
         dab_pkg::ST_IDLE: ;
         dab_pkg::ST_S0, dab_pkg::ST_S1: begin
            pins_d.uas_n = 1'b0;
            pins_d.ad_oe = 1'b1;
         end
         dab_pkg::ST_S2: begin
            pins_d.as_n  = 1'b0;
            pins_d.ad_oe = 1'b1;
            pins_d.rw    = rd;
            strobe_on    = rd;
            pins_d.data_direction  = wr;
            pins_d.ack_n = !(rd && dev);
         end
         default: begin
            // Data phase: S3 onward, including the wait states.
            pins_d.as_n   = (state_d == dab_pkg::ST_S7 && rd)
                         || state_d == dab_pkg::ST_S9;
            pins_d.rw     = rd;
            pins_d.data_direction   = wr;
            pins_d.data_buffer_enable_n = state_d == dab_pkg::ST_S7 && rd;
            pins_d.ad_oe  = wr;
            pins_d.ack_n  = !dev;
            if (rd) begin
               strobe_on = state_d != dab_pkg::ST_S7;
               pins_d.dtc_n = !(norm && (state_d == dab_pkg::ST_S6
                             || state_d == dab_pkg::ST_S7));
            end else begin
               strobe_on = state_d inside {dab_pkg::ST_S5, dab_pkg::ST_S6, dab_pkg::ST_S7,
                                           dab_pkg::ST_S8, dab_pkg::ST_E1, dab_pkg::ST_E2,
                                           dab_pkg::ST_W1};
               pins_d.dtc_n = !(norm && (state_d == dab_pkg::ST_S8
                             || state_d == dab_pkg::ST_S9));
            end
         end
      endcase
      if (wr && pins_d.ad_oe && state_d != dab_pkg::ST_S0 && state_d != dab_pkg::ST_S1
          && state_d != dab_pkg::ST_S2) pins_d.ad = hold_d;
      pins_d.last_n = pins_d.ack_n || !cyc_d.last;
      // A 16-bit bus uses two strobes; an 8-bit bus uses one data strobe.
      if (bus16_q) begin
         pins_d.upper_strobe_or_addr_zero   = !(strobe_on && (!cyc_d.byte_op || upper));
         pins_d.lower_strobe_or_single_strobe_n = !(strobe_on && (!cyc_d.byte_op || !upper));
      end else begin
         pins_d.lower_strobe_or_single_strobe_n = !strobe_on;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pins <= '{fc: 3'h0, fc_oe: 1'b0, addr_lo: 7'h00, ad: 16'h0000, ad_oe: 1'b0,
                   uas_n: 1'b1, as_n: 1'b1, rw: 1'b1, upper_strobe_or_addr_zero: 1'b1, lower_strobe_or_single_strobe_n: 1'b1,
                   ctl_oe: 1'b0, data_buffer_enable_n: 1'b1, data_direction: 1'b1, ack_n: 1'b1, last_n: 1'b1,
                   dtc_n: 1'b1};
      end else begin
         pins <= pins_d;
      end
   end
endmodule : dab_cycle

/* dab_cycle_sva.sv */
// Concurrent checks on the pins of the dual-address bus cycle sequencer.
`timescale 1ns/1ps
module dab_cycle_sva (
   input wire logic               clk,
   input wire logic               rst_n,
   input wire logic               req_valid,
   input wire logic               req_ready,
   input wire dab_pkg::dab_req_t  req,
   input wire dab_pkg::dab_chan_t chan,
   input wire logic               done,
   input wire dab_pkg::dab_term_t done_status,
   input wire logic               bus16,
   input wire dab_pkg::dab_pins_t pins
);
   logic acc;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // A request is taken on an edge where both handshake signals are high.
   assign acc = req_valid && req_ready;
   // Address phase, strobe order and direction of each cycle kind.
   addr_phase_a: assert property (acc |=> !pins.uas_n && pins.fc_oe && pins.rw &&
      pins.fc == (req.to_dev ? chan.dev_fc : chan.mem_fc)) else $error("address phase wrong");
   strobe_order_a: assert property (acc |=> !pins.uas_n [*2] ##1
      (pins.uas_n && !pins.as_n)) else $error("strobe order wrong");
   read_turn_a: assert property (acc && !req.write |=> ##2 !pins.data_direction ##1
      (!pins.data_buffer_enable_n && !pins.ad_oe)) else $error("read turnaround wrong");
   write_dir_a: assert property (acc && req.write |=> pins.data_direction && pins.rw ##2
      !pins.rw ##1 (!pins.rw && !pins.data_buffer_enable_n && pins.ad_oe)) else $error("write direction wrong");
   addr_zero_a: assert property (acc && !bus16 |=> pins.upper_strobe_or_addr_zero ==
      (req.to_dev ? req.dev8 && chan.dev_addr[0] : chan.mem_addr[0])) else $error("a0 wrong");
   // Transfer complete only ever precedes a normal finish.
   dtc_normal_a: assert property (!pins.dtc_n |-> ##[1:3]
      (done && done_status == dab_pkg::TC_NORMAL)) else $error("dtc without normal end");
   // Cycle end: strobes drop together, device signals follow one clock later.
   strobe_off_a: assert property ($rose(pins.as_n) |-> pins.lower_strobe_or_single_strobe_n &&
      (pins.upper_strobe_or_addr_zero || !bus16) && (pins.data_buffer_enable_n || !pins.rw)) else $error("strobes still on");
   end_release_a: assert property ($rose(pins.as_n) |=> pins.ack_n && pins.last_n &&
      pins.dtc_n && pins.data_direction) else $error("device signals not released");
   write_end_a: assert property ($rose(pins.as_n) && !pins.rw |=>
      pins.data_buffer_enable_n && pins.rw) else $error("write end not restored");
   // Main scenarios seen.
   rd_norm_c: cover property (acc && !req.write ##[8:60]
      done && done_status == dab_pkg::TC_NORMAL);
   wr_norm_c: cover property (acc && req.write ##[8:60] done && done_status == dab_pkg::TC_NORMAL);
   abort_c: cover property (done && done_status == dab_pkg::TC_RESET);
endmodule : dab_cycle_sva

bind dab_cycle dab_cycle_sva u_sva (.clk(clk), .rst_n(rst_n), .req_valid(req_valid),
   .req_ready(req_ready), .req(req), .chan(chan), .done(done), .done_status(done_status),
   .bus16(bus16), .pins(pins));

/* dab_bus_model.sv */
// Behavioural memory or peripheral on the asynchronous multiplexed bus.
`timescale 1ns/1ps
`include "dab_defines.svh"
module dab_bus_model (
   input  wire logic               clk,
   input  wire logic               rst_n,
   input  wire dab_pkg::dab_pins_t pins,
   input  wire logic [3:0]         dly,
   input  wire logic [2:0]         code,
   input  wire logic [15:0]        rdata,
   output logic      [15:0]        ad_in,
   output logic                    dack_n,
   output logic      [2:0]         bec,
   output logic      [15:0]        wr_data
);
   logic [4:0] cnt;
   // Answers a cycle dly clocks after the latch strobe, so a fast answer is seen by the end of S3.
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt     <= 5'h00;
         dack_n  <= 1'b1;
         bec     <= `DAB_BEC_NORMAL;
         ad_in   <= 16'h0000;
         wr_data <= 16'h0000;
      end else if (pins.as_n && pins.uas_n) begin
         cnt    <= 5'h00;
         dack_n <= 1'b1; // Termination is withdrawn only once the strobe is off.
         bec    <= `DAB_BEC_NORMAL;
         ad_in  <= ~ad_in; // Released lines show a changing pattern.
      end else begin
         cnt   <= cnt + 5'h01;
         ad_in <= pins.rw ? rdata : ~ad_in;
         if (cnt == 5'(dly)) begin
            if (code == `DAB_BEC_NORMAL) dack_n <= 1'b0;
            else bec <= code;
         end
         // A halt stands four clocks, then the cycle is acknowledged.
         if (code == `DAB_BEC_HALT && cnt == 5'(dly) + 5'h04) begin
            bec    <= `DAB_BEC_NORMAL;
            dack_n <= 1'b0;
         end
         if (!pins.rw && pins.ad_oe && !pins.data_buffer_enable_n) wr_data <= pins.ad;
      end
   end
endmodule : dab_bus_model

/* dab_cycle_tb.sv */
// Self-checking bench for the dual-address bus cycle sequencer.
`timescale 1ns/1ps
`include "dab_defines.svh"
module dab_cycle_tb;
   logic               clk, rst_n, req_valid, req_ready, done, bus16, bus_ready, dack_n, steer;
   logic               dtc_seen, ack_seen, last_seen;
   dab_pkg::dab_req_t  req;
   dab_pkg::dab_chan_t chan;
   dab_pkg::dab_term_t done_status;
   dab_pkg::dab_pins_t pins;
   logic [15:0]        hold_data, ad_in, rdata, wr_data, exp_h;
   logic [2:0]         bec, code;
   logic [3:0]         dly;
   logic [31:0]        seed;
   logic [2:0]         codes [6];
   int                 err_count, checks_done;

   dab_cycle DUT (.clk(clk), .rst_n(rst_n), .req_valid(req_valid), .req_ready(req_ready),
      .req(req), .chan(chan), .done(done), .done_status(done_status), .hold_data(hold_data),
      .bus16(bus16), .bus_ready(bus_ready), .pins(pins), .ad_in(ad_in),
      .transfer_acknowledge_n(dack_n), .bus_exception_code(bec), .upper_byte_steer(steer));
   dab_bus_model u_mem (.clk(clk), .rst_n(rst_n), .pins(pins), .dly(dly), .code(code),
      .rdata(rdata), .ad_in(ad_in), .dack_n(dack_n), .bec(bec), .wr_data(wr_data));

   // Clock at 100 MHz.
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // Notes which device-side signals showed during the current cycle.
   always @(negedge clk) begin
      if (!pins.dtc_n) dtc_seen = 1'b1;
      if (!pins.ack_n) ack_seen = 1'b1;
      if (!pins.last_n) last_seen = 1'b1;
   end

   function automatic logic [31:0] rnd();
      seed = {seed[30:0], 1'b0} ^ (seed[31] ? 32'h04C11DB7 : 32'h00000000);
      return seed;
   endfunction : rnd
   // Termination class expected for a code; a halt ends later as normal.
   function automatic dab_pkg::dab_term_t cls(logic [2:0] c);
      case (c)
         `DAB_BEC_BERR: return dab_pkg::TC_BERR;
         `DAB_BEC_RETRY: return dab_pkg::TC_RETRY;
         `DAB_BEC_RELRETRY: return dab_pkg::TC_RELRETRY;
         `DAB_BEC_RESET: return dab_pkg::TC_RESET;
         default: return dab_pkg::TC_NORMAL;
      endcase
   endfunction : cls
   // Holding register after a read: a byte on the wide bus keeps the other lane.
   function automatic logic [15:0] lane(logic [15:0] old, logic [15:0] rd,
                                        dab_pkg::dab_req_t r, logic a0, logic b16);
      if (!b16 || !r.byte_op) return rd;
      if ((r.to_dev && r.dev8) ? !r.dev_odd : !a0) return {rd[15:8], old[7:0]};
      return {old[15:8], rd[7:0]};
   endfunction : lane

   task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_count++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : stop_test
   // Waits at most 300 clocks for a settled high level.
   task automatic wait_hi(ref logic s);
      int i;
      i = 0;
      do begin
         @(negedge clk);
         i++;
      end while (s !== 1'b1 && i < 300);
      if (i >= 300) begin
         err_count++;
         stop_test();
      end
   endtask : wait_hi
   // One cycle with code c; b2b holds the request so it repeats at once.
   task automatic send(input logic [2:0] c, input logic b2b, input logic fw);
      logic [31:0]        r, r2;
      dab_pkg::dab_req_t  rq;
      dab_pkg::dab_chan_t ch;
      r = rnd();
      r2 = rnd();
      rq = {r[5:0], r[31:16]};
      rq.write = rq.write | fw;
      ch = 54'({rnd(), r2});
      @(posedge clk);
      req <= rq;
      chan <= ch;
      dly <= {1'b0, r[8:6]};
      code <= c;
      rdata <= r2[15:0];
      req_valid <= 1'b1;
      wait_hi(req_ready);
      @(posedge clk);
      req_valid <= b2b;
      if (rq.write) exp_h = rq.wdata;
      else if (cls(c) == dab_pkg::TC_NORMAL)
         exp_h = lane(exp_h, r2[15:0], rq, rq.to_dev ? ch.dev_addr[0] : ch.mem_addr[0], steer);
      for (int k = 0; k <= int'(b2b); k++) begin
         {dtc_seen, ack_seen, last_seen} = 3'h0;
         wait_hi(done);
         check("status", 16'(done_status), 16'(cls(c)));
         check("hold", hold_data, exp_h);
         check("dtc", 16'(dtc_seen), 16'(cls(c) == dab_pkg::TC_NORMAL));
         check("ack", 16'(ack_seen), 16'(rq.to_dev));
         check("last", 16'(last_seen), 16'(rq.to_dev && rq.last));
         if (rq.write && !rq.byte_op && steer && c == `DAB_BEC_NORMAL)
            check("wdata", wr_data, rq.wdata);
         if (b2b && k == 0) begin
            check("restart", 16'(pins.uas_n), 16'h0000);
            @(posedge clk);
            req_valid <= 1'b0;
         end
      end
      // A reset code stays visible through the synchroniser for a few clocks after the abort.
      if (c == `DAB_BEC_RESET) repeat (4) @(posedge clk);
   endtask : send

   // Two runs: wide bus, then narrow bus after a second reset.
   initial begin
      logic [31:0] v;
      seed = 32'h12EEF4EF;
      codes = '{`DAB_BEC_NORMAL, `DAB_BEC_BERR, `DAB_BEC_RETRY, `DAB_BEC_RELRETRY,
                `DAB_BEC_HALT, `DAB_BEC_RESET};
      {rst_n, req_valid, dtc_seen, ack_seen, last_seen, steer} = 6'h01;
      req = '0;
      chan = '0;
      dly = 4'h0;
      code = `DAB_BEC_NORMAL;
      rdata = 16'h0000;
      exp_h = 16'h0000;
      err_count = 0;
      checks_done = 0;
      for (int p = 0; p < 2; p++) begin
         @(posedge clk);
         rst_n <= 1'b0;
         steer <= (p == 0);
         repeat (16) @(posedge clk);
         rst_n <= 1'b1;
         wait_hi(bus_ready);
         check("bus16", 16'(bus16), 16'(p == 0));
         send(`DAB_BEC_NORMAL, 1'b0, 1'b1);
         for (int k = 0; k < 6; k++) send(codes[k], 1'b0, 1'b0);
         for (int k = 0; k < 30; k++) begin
            v = rnd();
            code = (v[3:1] == 3'h0) ? codes[v[6:4] % 6] : `DAB_BEC_NORMAL;
            send(code, v[0] && code == `DAB_BEC_NORMAL, 1'b0);
         end
      end
      stop_test();
   end
endmodule : dab_cycle_tb
